// file: verilog/fcs_host.sv
/*
 * fcs_host: host-side controller that issues command sequences to a parallel flash
 * and polls completion on the poll bit. assumes one request at a time, single clock.
 */
`timescale 1ns/1ps
`default_nettype none
module fcs_host #(
    parameter int QUEUE_GAP_CYC = fcs_pkg::QUEUE_GAP_CYC,
    parameter int POLL_LIMIT = 32'd4000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request port
    input wire logic req_valid,
    output logic req_ready,
    input wire fcs_pkg::fcs_req_s req,
    // answer port
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_error,
    output logic parity_ok,
    output logic queue_open,
    // flash pins
    output logic [18:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'h0,
        HS_ISSUE = 3'h1,
        HS_WAIT = 3'h2,
        HS_POLL = 3'h3,
        HS_POLL_WAIT = 3'h4,
        HS_DONE = 3'h5
    } fcs_hs_e;

    fcs_hs_e state;
    fcs_pkg::fcs_req_s cur;
    logic [2:0] step;
    logic [31:0] poll_cnt;
    logic [31:0] gap_cnt;
    logic start;
    logic done;
    logic [7:0] rdata;
    fcs_pkg::fcs_cycle_s cyc;

    // number of bus cycles each operation needs
    wire logic is_erase = (cur.op == fcs_pkg::OP_CHIP_ERASE) || (cur.op == fcs_pkg::OP_SECTOR_ERASE);
    wire logic short_op = (cur.op == fcs_pkg::OP_SUSPEND) || (cur.op == fcs_pkg::OP_RESUME)
        || (cur.op == fcs_pkg::OP_READ) || (cur.append && cur.op == fcs_pkg::OP_SECTOR_ERASE);
    wire logic [2:0] last_step = short_op ? 3'd0 : (is_erase ? 3'd5 : 3'd3);
    wire logic needs_poll = (cur.op == fcs_pkg::OP_PROGRAM) || is_erase;
    // unlock pairs: steps 0,1 and 3,4 of erase
    wire logic unlock_a = (step == 3'd0) || (is_erase && step == 3'd3);
    wire logic unlock_b = (step == 3'd1) || (is_erase && step == 3'd4);
    wire logic [7:0] third_byte =
        (cur.op == fcs_pkg::OP_RESET) ? fcs_pkg::CMD_RESET :
        (cur.op == fcs_pkg::OP_IDENT) ? fcs_pkg::CMD_IDENT :
        (cur.op == fcs_pkg::OP_PROGRAM) ? fcs_pkg::CMD_PROGRAM : fcs_pkg::CMD_ERASE_SETUP;
    wire logic [7:0] final_erase = (cur.op == fcs_pkg::OP_CHIP_ERASE) ?
        fcs_pkg::CMD_CHIP_ERASE : fcs_pkg::CMD_SECTOR_ERASE;
    wire logic [18:0] final_erase_addr = (cur.op == fcs_pkg::OP_CHIP_ERASE) ?
        fcs_pkg::UNLOCK_ADDR_A : cur.addr;
    wire logic [7:0] short_byte = (cur.op == fcs_pkg::OP_SUSPEND) ? fcs_pkg::CMD_SUSPEND :
        fcs_pkg::CMD_RESUME;
    // the four-cycle ident/reset/program forms end at step 3; ident and reset have no step 3 write
    wire logic tail_read = !short_op && !is_erase && (step == 3'd3) && (cur.op != fcs_pkg::OP_PROGRAM);

    always_comb begin
        cyc.write = 1'b1;
        cyc.addr = cur.addr;
        cyc.data = cur.data;
        if (short_op) begin
            cyc.write = (cur.op != fcs_pkg::OP_READ);
            cyc.data = (cur.op == fcs_pkg::OP_SECTOR_ERASE) ? fcs_pkg::CMD_SECTOR_ERASE : short_byte;
        end else if (state == HS_POLL || state == HS_POLL_WAIT) begin
            // the cycle unit takes cyc one clock after HS_POLL raises start
            cyc.write = 1'b0;
        end else if (unlock_a) begin
            cyc.addr = fcs_pkg::UNLOCK_ADDR_A;
            cyc.data = fcs_pkg::UNLOCK_DATA_A;
        end else if (unlock_b) begin
            cyc.addr = fcs_pkg::UNLOCK_ADDR_B;
            cyc.data = fcs_pkg::UNLOCK_DATA_B;
        end else if (step == 3'd2) begin
            cyc.addr = fcs_pkg::UNLOCK_ADDR_A;
            cyc.data = third_byte;
        end else if (step == 3'd5) begin
            cyc.addr = final_erase_addr;
            cyc.data = final_erase;
        end else if (tail_read) begin
            cyc.write = 1'b0;
        end
    end

    // erase completes when poll bit reads one; program when it equals bit 7 written
    wire logic poll_target = is_erase ? 1'b1 : cur.data[7];
    wire logic poll_hit = (rdata[7] == poll_target);

    assign req_ready = (state == HS_IDLE);
    assign queue_open = (gap_cnt != 32'd0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= HS_IDLE;
            cur <= '0;
            step <= '0;
            start <= 1'b0;
            poll_cnt <= '0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            rsp_error <= 1'b0;
            parity_ok <= 1'b0;
        end else begin
            start <= 1'b0;
            rsp_valid <= 1'b0;
            case (state)
                HS_IDLE: begin
                    if (req_valid) begin
                        cur <= req;
                        step <= '0;
                        state <= HS_ISSUE;
                    end
                end
                HS_ISSUE: begin
                    start <= 1'b1;
                    state <= HS_WAIT;
                end
                HS_WAIT: begin
                    if (done) begin
                        if (step == last_step) begin
                            state <= (needs_poll && !short_op) ? HS_POLL : HS_DONE;
                            poll_cnt <= '0;
                        end else begin
                            step <= step + 3'd1;
                            state <= HS_ISSUE;
                        end
                    end
                end
                HS_POLL: begin
                    start <= 1'b1;
                    state <= HS_POLL_WAIT;
                end
                HS_POLL_WAIT: begin
                    if (done) begin
                        poll_cnt <= poll_cnt + 32'd1;
                        if (poll_hit || poll_cnt == POLL_LIMIT[31:0]) begin
                            rsp_error <= !poll_hit;
                            state <= HS_DONE;
                        end else begin
                            state <= HS_POLL;
                        end
                    end
                end
                HS_DONE: begin
                    rsp_valid <= 1'b1;
                    rsp_data <= rdata;
                    parity_ok <= ^rdata;
                    if (!needs_poll || short_op) begin
                        rsp_error <= 1'b0;
                    end
                    state <= HS_IDLE;
                end
                default: state <= HS_IDLE;
            endcase
        end
    end

    // window timer for appending sectors; restarted by each sector erase final write
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_cnt <= '0;
        end else if (done && state == HS_WAIT && cur.op == fcs_pkg::OP_SECTOR_ERASE && step == last_step) begin
            gap_cnt <= QUEUE_GAP_CYC[31:0] - 32'd1;
        end else if (gap_cnt != 32'd0) begin
            gap_cnt <= gap_cnt - 32'd1;
        end
    end

    fcs_bus_cycle u_cycle (
        .clk(clk),
        .arst_n(arst_n),
        .start(start),
        .cyc(cyc),
        .done(done),
        .rdata(rdata),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n),
        .flash_oe_n(flash_oe_n)
    );
endmodule // fcs_host
`default_nettype wire

// file: verilog/fcs_pkg.sv
/*
 * fcs_pkg: constants and carrier types for the flash command host controller.
 * assumes a byte-wide parallel flash with 19 address bits, driven by the host.
 */
`default_nettype none
package fcs_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // unlock and command encodings
    localparam logic [18:0] UNLOCK_ADDR_A = 19'h05555;
    localparam logic [18:0] UNLOCK_ADDR_B = 19'h02AAA;
    localparam logic [7:0] UNLOCK_DATA_A = 8'hAA;
    localparam logic [7:0] UNLOCK_DATA_B = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_IDENT = 8'h90;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    // identification read addresses
    localparam logic [18:0] ID_MAKER_ADDR = 19'h00000;
    localparam logic [18:0] ID_PART_ADDR = 19'h00001;
    localparam logic [18:0] ID_PROTECT_ADDR = 19'h00002;
    localparam int SECTOR_LSB = 16;
    // bus timing in clock cycles at 40 ns
    localparam int CLK_NS = 40;
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_NS = 160;
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    // accepted spacing of queued sector erase writes: below 80 ms
    localparam int QUEUE_GAP_MS = 80;
    localparam int QUEUE_GAP_CYC = QUEUE_GAP_MS * 25000;
    localparam int CNT_W = 8;

    typedef enum logic [2:0] {
        OP_RESET = 3'h0,
        OP_IDENT = 3'h1,
        OP_PROGRAM = 3'h2,
        OP_CHIP_ERASE = 3'h3,
        OP_SECTOR_ERASE = 3'h4,
        OP_SUSPEND = 3'h5,
        OP_RESUME = 3'h6,
        OP_READ = 3'h7
    } fcs_op_e;

    typedef struct packed {
        fcs_op_e op;
        logic [18:0] addr;
        logic [7:0] data;
        logic append;
    } fcs_req_s;

    typedef struct packed {
        logic [18:0] addr;
        logic [7:0] data;
        logic write;
    } fcs_cycle_s;
endpackage : fcs_pkg
`default_nettype wire

// file: verilog/fcs_bus_cycle.sv
/*
 * fcs_bus_cycle: one read or write cycle on the flash parallel pins.
 * assumes the flash answers reads within READ_CYC clocks; data pins are split in/out/enable.
 */
`timescale 1ns/1ps
`default_nettype none
module fcs_bus_cycle #(
    parameter int STROBE_CYC = fcs_pkg::STROBE_CYC,
    parameter int READ_CYC = fcs_pkg::READ_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // cycle request
    input wire logic start,
    input wire fcs_pkg::fcs_cycle_s cyc,
    output logic done,
    output logic [7:0] rdata,
    // flash pins
    output logic [18:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n
);
    typedef enum logic [1:0] {
        BC_IDLE = 2'h0,
        BC_SETUP = 2'h1,
        BC_STROBE = 2'h2,
        BC_HOLD = 2'h3
    } fcs_bc_e;

    fcs_bc_e state;
    logic [fcs_pkg::CNT_W-1:0] cnt;
    logic is_write;
    wire logic [fcs_pkg::CNT_W-1:0] len = is_write ? fcs_pkg::CNT_W'(STROBE_CYC) : fcs_pkg::CNT_W'(READ_CYC);
    wire logic cnt_end = (cnt == len - fcs_pkg::CNT_W'(1));

    assign done = (state == BC_HOLD);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= BC_IDLE;
            cnt <= '0;
            is_write <= 1'b0;
            flash_addr <= '0;
            flash_dq_out <= '0;
            flash_dq_oe <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            rdata <= '0;
        end else begin
            case (state)
                BC_IDLE: begin
                    if (start) begin
                        // address set up a cycle ahead so the later falling edge is we_n
                        flash_addr <= cyc.addr;
                        flash_dq_out <= cyc.data;
                        flash_dq_oe <= cyc.write;
                        is_write <= cyc.write;
                        flash_ce_n <= 1'b0;
                        state <= BC_SETUP;
                    end
                end
                BC_SETUP: begin
                    flash_we_n <= ~is_write;
                    flash_oe_n <= is_write;
                    cnt <= '0;
                    state <= BC_STROBE;
                end
                BC_STROBE: begin
                    cnt <= cnt + fcs_pkg::CNT_W'(1);
                    if (cnt_end) begin
                        // we_n rises first, before ce_n, so data latches here
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        if (!is_write) begin
                            rdata <= flash_dq_in;
                        end
                        state <= BC_HOLD;
                    end
                end
                BC_HOLD: begin
                    flash_ce_n <= 1'b1;
                    flash_dq_oe <= 1'b0;
                    state <= BC_IDLE;
                end
                default: state <= BC_IDLE;
            endcase
        end
    end
endmodule // fcs_bus_cycle
`default_nettype wire

// file: verification/fcs_host_monitor.sv
/* fcs_host_monitor: port checks of the flash command host controller.
   assumes a bind to fcs_host, one clock and an async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module fcs_host_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // request and answer
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic parity_ok,
    // flash pins
    input wire logic [18:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // write strobe low two clocks, chip select released one clock after it
    sequence s_we_pulse;
        !flash_we_n [*2] ##1 flash_we_n && !flash_ce_n ##1 flash_ce_n;
    endsequence
    chk_take_busy: assert property (req_valid && req_ready |=> !req_ready)
        else $error("request taken but port still ready");
    chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer pulse longer than one cycle");
    chk_we_inside: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
        else $error("write strobe outside a driven selected cycle");
    chk_we_late_fall: assert property ($fell(flash_we_n) |-> $past(flash_ce_n) == 1'b0)
        else $error("write strobe fell before chip select");
    chk_we_pulse: assert property ($fell(flash_we_n) |-> s_we_pulse)
        else $error("write strobe shape wrong");
    chk_write_hold: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
        else $error("address or data moved during write strobe");
    chk_read_quiet: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n && !flash_ce_n)
        else $error("read strobe while host drives data");
    chk_parity_flag: assert property (rsp_valid |=> parity_ok == ^rsp_data)
        else $error("parity flag disagrees with answer byte");
    chk_idle_pins: assert property (req_ready |-> flash_ce_n && flash_we_n && flash_oe_n)
        else $error("bus active while idle");
endmodule // fcs_host_monitor
`default_nettype wire

// file: verification/fcs_flash_model.sv
/* fcs_flash_model: behavioural byte-wide sector flash on the far side of the host.
   assumes pins sampled on the host clock; counts replace the device's real times. */
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
    parameter int PROG_CYC = 20,
    parameter int ERASE_CYC = 40,
    parameter int WIN_CYC = 62,
    // identification codes: arbitrary values with odd parity
    parameter logic [7:0] MAKER = 8'h01,
    parameter logic [7:0] PART = 8'h83,
    parameter logic [7:0] PROT = 8'h04
) (
    // clock
    input wire logic clk,
    // flash pins
    input wire logic [18:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n,
    output logic [7:0] flash_dq_in
);
    logic [7:0] mem [0:524287];
    logic [18:0] la = '0;
    logic [7:0] pd = 8'h00;
    logic [7:0] sel = 8'h00;
    logic we_d = 1'b1;
    logic ident = 1'b0;
    int step = 0;
    int mode = 0;
    int busy = 0;
    int win = 0;
    initial begin
        for (int i = 0; i < 524288; i++) mem[i] = 8'hFF;
        flash_dq_in = 8'h5A;
    end
    task automatic finish_op();
        if (mode > 1) for (int i = 0; i < 524288; i++) if (sel[i >> 16] && !PROT[i >> 16]) mem[i] = 8'hFF;
        mode = 0;
    endtask
    task automatic wr(logic [18:0] a, logic [7:0] d);
        logic u1;
        logic u2;
        u1 = a[10:0] == 11'h555;
        u2 = a[10:0] == 11'h2AA;
        if (mode == 1 || mode == 2) return;
        if (mode == 3 || win > 0) begin
            if (d == 8'h30) sel[a[18:16]] = 1'b1;
            else if (d != 8'hB0) begin
                mode = 0;
                win = 0;
                busy = 0;
            end
            step = 0;
            return;
        end
        // program data of F0 is data, not a reset
        if (d == 8'hF0 && step != 6) begin
            ident = 1'b0;
            step = 0;
            return;
        end
        case (step)
            0, 3: step = (u1 && d == 8'hAA) ? step + 1 : 0;
            1, 4: step = (u2 && d == 8'h55) ? step + 1 : 0;
            2: begin
                step = (u1 && d == 8'hA0) ? 6 : (u1 && d == 8'h80) ? 3 : 0;
                if (u1 && d == 8'h90) ident = 1'b1;
            end
            5: begin
                step = 0;
                if (u1 && d == 8'h10) begin
                    sel = 8'hFF;
                    mode = 2;
                    busy = ERASE_CYC;
                end else if (d == 8'h30) begin
                    sel = 8'h00;
                    sel[a[18:16]] = 1'b1;
                    mode = 3;
                    win = WIN_CYC;
                end
            end
            6: begin
                step = 0;
                mem[a] = mem[a] & d;
                pd = d;
                mode = 1;
                busy = PROG_CYC;
            end
            default: step = 0;
        endcase
    endtask
    function automatic logic [7:0] rd(logic [18:0] a);
        if (mode == 1) return {~pd[7], 7'h00};
        if (mode > 1) return 8'h00;
        if (ident) return a[1] ? {7'h00, PROT[a[18:16]]} : (a[0] ? PART : MAKER);
        return mem[a];
    endfunction
    always @(posedge clk) begin
        if (win > 0) begin
            win--;
            if (win == 0) busy = ERASE_CYC;
        end
        if (busy > 0) begin
            busy--;
            if (busy == 0) finish_op();
        end
        if (!flash_ce_n && we_d && !flash_we_n) begin
            la = flash_addr;
            if (win > 0) win = WIN_CYC;
        end
        if (!flash_ce_n && !we_d && flash_we_n && flash_dq_oe) wr(la, flash_dq_out);
        we_d = flash_we_n;
        flash_dq_in <= (!flash_ce_n && !flash_oe_n) ? rd(flash_addr) : ~flash_dq_in;
    end
endmodule // fcs_flash_model
`default_nettype wire

// file: verification/fcs_host_tb.sv
/* fcs_host_tb: self-checking bench of the flash command host against a flash model.
   assumes fcs_pkg, fcs_host, fcs_flash_model and fcs_host_monitor are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module fcs_host_tb;
    localparam int LIMIT = 20000;
    localparam logic [7:0] MAKER = 8'h01;
    localparam logic [7:0] PART = 8'h83;
    localparam logic [7:0] PROT = 8'h04;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    fcs_pkg::fcs_req_s req = '0;
    logic req_ready, rsp_valid, rsp_error, parity_ok, queue_open;
    logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
    logic [7:0] rsp_data, flash_dq_out, flash_dq_in;
    logic [18:0] flash_addr;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h1D54;
    int ref_mem[int];
    int addrs[$];
    fcs_host #(.QUEUE_GAP_CYC(50), .POLL_LIMIT(200)) u_dut (.clk(clk), .arst_n(arst_n),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_error(rsp_error), .parity_ok(parity_ok), .queue_open(queue_open),
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
    fcs_flash_model #(.MAKER(MAKER), .PART(PART), .PROT(PROT)) u_flash (.clk(clk), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_dq_in(flash_dq_in));
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_rd(logic [18:0] a);
        return ref_mem.exists(a) ? ref_mem[a][7:0] : 8'hFF;
    endfunction
    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic op(fcs_pkg::fcs_op_e o, logic [18:0] a, logic [7:0] d, int e);
        req_valid <= 1'b1;
        // data bit 0 of a sector erase request selects the one-write append form
        req <= '{op: o, addr: a, data: d, append: (o == fcs_pkg::OP_SECTOR_ERASE) && d[0]};
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge clk); while (rsp_valid !== 1'b1);
        chk("rsp_error", {7'h00, rsp_error}, 8'h00);
        if (e >= 0) chk("rsp_data", rsp_data, e[7:0]);
    endtask
    task automatic prog(logic [18:0] a, logic [7:0] d);
        logic [7:0] e;
        e = exp_rd(a) & d;
        op(fcs_pkg::OP_PROGRAM, a, d, e);
        ref_mem[a] = e;
        addrs.push_back(a);
    endtask
    task automatic erase_check(logic [7:0] s);
        foreach (addrs[i]) if (s[addrs[i] >> 16] && !PROT[addrs[i] >> 16]) ref_mem[addrs[i]] = 255;
        foreach (addrs[i]) op(fcs_pkg::OP_READ, addrs[i], 8'h00, exp_rd(addrs[i]));
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        logic [18:0] a;
        a = '0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        op(fcs_pkg::OP_READ, 19'h12345, 8'h00, 8'hFF);
        op(fcs_pkg::OP_IDENT, 19'h7F800, 8'h00, MAKER);
        chk("parity_ok", {7'h00, parity_ok}, 8'h01);
        op(fcs_pkg::OP_READ, 19'h00001, 8'h00, PART);
        chk("parity_ok", {7'h00, parity_ok}, 8'h01);
        op(fcs_pkg::OP_READ, 19'h20002, 8'h00, 8'h01);
        op(fcs_pkg::OP_READ, 19'h50002, 8'h00, 8'h00);
        op(fcs_pkg::OP_RESET, 19'h00000, 8'h00, -1);
        op(fcs_pkg::OP_READ, 19'h00000, 8'h00, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            if (!i[0]) a = {3'h1, seed[15:0]};
            // bit 7 never asked to go zero to one, so the poll bit can match
            prog(a, seed[23:16] & (exp_rd(a) | 8'h7F));
            op(fcs_pkg::OP_READ, a, 8'h00, exp_rd(a));
        end
        prog(19'h20010, 8'h3C);
        op(fcs_pkg::OP_CHIP_ERASE, 19'h10000, 8'h00, 8'hFF);
        erase_check(8'hFF);
        prog(19'h40004, 8'h12);
        prog(19'h50005, 8'h34);
        op(fcs_pkg::OP_SECTOR_ERASE, 19'h40004, 8'h00, 8'hFF);
        chk("queue_open", {7'h00, queue_open}, 8'h00);
        erase_check(8'h10);
        prog(19'h60006, 8'h56);
        // host reset while the flash runs a sector erase; the erase is then issued again
        req_valid <= 1'b1;
        req <= '{op: fcs_pkg::OP_SECTOR_ERASE, addr: 19'h60006, data: 8'h00, append: 1'b0};
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (45) @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (150) @(posedge clk);
        chk("req_ready", {7'h00, req_ready}, 8'h01);
        op(fcs_pkg::OP_SECTOR_ERASE, 19'h60006, 8'h00, 8'hFF);
        erase_check(8'h40);
        op(fcs_pkg::OP_SECTOR_ERASE, 19'h50005, 8'h01, -1);
        chk("queue_open", {7'h00, queue_open}, 8'h01);
        op(fcs_pkg::OP_SUSPEND, 19'h00000, 8'h00, -1);
        op(fcs_pkg::OP_RESUME, 19'h00000, 8'h00, -1);
        op(fcs_pkg::OP_READ, 19'h50005, 8'h00, 8'h34);
        end_sim();
    end
endmodule // fcs_host_tb
bind fcs_host fcs_host_monitor u_mon (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .parity_ok(parity_ok), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
`default_nettype wire
